// ==== design/ccs_ratio_div.v ====
// one derived clock: tick enable and square level from a shared base count
// assumes base counts 0..23 on the source clock and wraps in step for all users
`timescale 1ns/1ns
`default_nettype none
`include "ccs_regs.vh"
module ccs_ratio_div (
   input  wire       clock,    // source clock
   input  wire       rst,      // sync reset, active high
   input  wire [4:0] base,     // shared base count
   input  wire [2:0] target,   // requested ratio code
   input  wire       periph,   // use peripheral encoding
   input  wire       hold,     // clocks stopped
   input  wire [2:0] resetCode, // ratio code after reset
   output reg        tick,     // one source cycle per derived period
   output reg        level,    // derived clock waveform
   output reg  [2:0] current   // ratio in force
);
   ////////////////////////////////////////////////////////////////////
   function [4:0] divisor;
      input [2:0] code;
      input       per;
      reg   [2:0] idx;
      begin
         idx = per ? code + 3'h1 : code;
         case (idx)
            3'h0:    divisor = 5'h01;
            3'h1:    divisor = 5'h02;
            3'h2:    divisor = 5'h03;
            3'h3:    divisor = 5'h04;
            3'h4:    divisor = 5'h06;
            3'h5:    divisor = 5'h08;
            default: divisor = 5'h08;
         endcase
      end
   endfunction

   wire [4:0] n     = divisor(current, periph);
   wire [4:0] phase = base % n;

   always @(posedge clock) begin
      if (rst) begin
         current <= resetCode;
         tick    <= 1'b0;
         level   <= 1'b0;
      end else begin
         // ratios change only where every period starts together
         if (base == `CCS_BASE_LAST)
            current <= target;
         tick  <= !hold && (phase == `CCS_BASE_ZERO);
         level <= !hold && ((n == 5'h01) || (phase < (n >> 1)));
      end
   end
endmodule // ccs_ratio_div
`default_nettype wire

// ==== design/ccs_regs.vh ====
// constants of the clock ratio and pll sequencer: register map, fields, keys
// assumes a 32-bit AHB-Lite data bus and one source clock
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
// byte addresses
`define CCS_ADDR_FREQ       32'hFFC0_0000
`define CCS_ADDR_COUNT      32'hFFC0_0008
`define CCS_ADDR_CSR        32'hFFC0_000C
// freq_ctrl fields
`define CCS_FRQ_OUT_EN      11
`define CCS_FRQ_PLL1        10
`define CCS_FRQ_PLL2        9
`define CCS_FRQ_CPU_HI      8
`define CCS_FRQ_CPU_LO      6
`define CCS_FRQ_BUS_HI      5
`define CCS_FRQ_BUS_LO      3
`define CCS_FRQ_PER_HI      2
`define CCS_FRQ_PER_LO      0
`define CCS_FRQ_WMASK       16'h0FFF
`define CCS_FRQ_RESET       16'h0E13
// timer control/status fields
`define CCS_CSR_RUN         7
`define CCS_CSR_SEL_HI      2
`define CCS_CSR_SEL_LO      0
`define CCS_CSR_RESET       8'h00
`define CCS_CNT_RESET       8'h00
`define CCS_CNT_MAX         8'hFF
// write keys in the upper byte of a halfword
`define CCS_KEY_COUNT       8'h5A
`define CCS_KEY_CSR         8'hA5
// bus encodings
`define CCS_HSIZE_BYTE      3'h0
`define CCS_HSIZE_HALF      3'h1
`define CCS_HSIZE_WORD      3'h2
// common boundary of all ratios (lcm of 1,2,3,4,6,8 is 24)
`define CCS_BASE_LAST       5'h17
`define CCS_BASE_ZERO       5'h00
// timer prescale: smallest division 32, doubled per select step
`define CCS_PRE_MAX_MASK    12'hFFF
`define CCS_PRE_ZERO        12'h000
`endif

// ==== design/ccs_sequencer.v ====
// clock ratio and pll sequencer: AHB-Lite register slave, pll start sequence,
// divided clock ticks and the external clock pin
// assumes one source clock; pll analog parts are driven by the pll enable outputs
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_regs.vh"
module ccs_sequencer (
   input  wire        clock,        // source clock, 250 MHz
   input  wire        rst,          // sync reset, active high
   input  wire        hsel,         // slave select
   input  wire [31:0] haddr,        // address
   input  wire [1:0]  htrans,       // transfer type
   input  wire        hwrite,       // write
   input  wire [2:0]  hsize,        // transfer size
   input  wire [31:0] hwdata,       // write data
   input  wire        hready,       // bus ready in
   output reg  [31:0] hrdata,       // read data
   output reg         hreadyout,    // slave ready
   output reg         hresp,        // response, always okay
   output reg         pll1On,       // first pll running
   output reg         pll2On,       // second pll running
   output reg         procHalt,     // processing halted
   output reg         cpuTick,      // cpu clock enable
   output reg         busTick,      // bus clock enable
   output reg         periphTick,   // peripheral clock enable
   output reg         extClockOut,  // external clock pin value
   output reg         extClockOe    // external clock pin drive enable
);
   localparam [1:0] ST_RUN   = 2'h0;
   localparam [1:0] ST_STAB1 = 2'h1;
   localparam [1:0] ST_STAB2 = 2'h2;
   localparam [15:0] FRQ_INIT = `CCS_FRQ_RESET;

   ////////////////////////////////////////////////////////////////////
   // bus slave
   reg  [15:0] freq_ctrl;
   reg  [1:0]  state;
   reg  [31:0] dAddr;
   reg  [2:0]  dSize;
   reg         dWrite;
   reg  [4:0]  base;
   reg  [2:0]  busTarget;
   reg         unstable;
   wire [7:0]  count;
   wire [7:0]  ctrl;
   wire        overflow;
   wire        cpuT;
   wire        busT;
   wire        perT;
   wire        busLevel;
   reg  [31:0] next_rdata;

   wire take = hsel && hready && htrans[1];
   wire halfWrite = dWrite && (dSize == `CCS_HSIZE_HALF);
   wire cntWrite = halfWrite && (dAddr == `CCS_ADDR_COUNT)
                   && (hwdata[15:8] == `CCS_KEY_COUNT);
   wire csrWrite = halfWrite && (dAddr == `CCS_ADDR_CSR)
                   && (hwdata[15:8] == `CCS_KEY_CSR);
   wire frqWrite = dWrite && (dAddr == `CCS_ADDR_FREQ) && (state == ST_RUN)
                   && ((dSize == `CCS_HSIZE_HALF) || (dSize == `CCS_HSIZE_WORD));
   wire [15:0] frqNew = hwdata[15:0] & `CCS_FRQ_WMASK;

   ////////////////////////////////////////////////////////////////////
   // ratio fields of a frequency control value
   function [2:0] cpu_field;
      input [15:0] value;
      begin
         cpu_field = value[`CCS_FRQ_CPU_HI:`CCS_FRQ_CPU_LO];
      end
   endfunction

   function [2:0] bus_field;
      input [15:0] value;
      begin
         bus_field = value[`CCS_FRQ_BUS_HI:`CCS_FRQ_BUS_LO];
      end
   endfunction

   function [2:0] per_field;
      input [15:0] value;
      begin
         per_field = value[`CCS_FRQ_PER_HI:`CCS_FRQ_PER_LO];
      end
   endfunction

   // writes that start a stabilization count
   wire pll1Start = frqWrite && frqNew[`CCS_FRQ_PLL1] && !freq_ctrl[`CCS_FRQ_PLL1];
   wire busHalt   = frqWrite && frqNew[`CCS_FRQ_PLL2] && pll2On
                    && (bus_field(frqNew) != bus_field(freq_ctrl));
   // ticks stop and the pin switches in the very cycle the halt begins
   wire haltNow   = procHalt || pll1Start || busHalt;

   always @(posedge clock) begin
      if (rst) begin
         dAddr     <= 32'h0000_0000;
         dSize     <= `CCS_HSIZE_BYTE;
         dWrite    <= 1'b0;
      end else begin
         dWrite <= take && hwrite;
         if (take) begin
            dAddr <= haddr;
            dSize <= hsize;
         end
      end
   end

   // reads of the timer registers give the byte in the low lane
   always @* begin
      case (haddr)
         `CCS_ADDR_FREQ:  next_rdata = {16'h0000, freq_ctrl};
         `CCS_ADDR_COUNT: next_rdata = {24'h00_0000, count};
         `CCS_ADDR_CSR:   next_rdata = {24'h00_0000, ctrl};
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   // read data is registered in the address phase
   always @(posedge clock) begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= next_rdata;
   end

   // zero wait states and only okay answers
   always @(posedge clock) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frequency control register and stabilization sequence
   always @(posedge clock) begin
      if (rst) begin
         freq_ctrl <= `CCS_FRQ_RESET;
         state     <= ST_RUN;
         pll1On    <= 1'b1;
         pll2On    <= 1'b1;
         procHalt  <= 1'b0;
         busTarget <= bus_field(FRQ_INIT);
      end else begin
         case (state)
            ST_RUN: begin
               if (frqWrite) begin
                  freq_ctrl <= frqNew;
                  pll2On    <= pll2On && frqNew[`CCS_FRQ_PLL2];
                  if (!frqNew[`CCS_FRQ_PLL1])
                     pll1On <= 1'b0;
                  if (pll1Start) begin
                     // first pll starts: one count, or two with the second on
                     pll1On   <= 1'b1;
                     pll2On   <= 1'b0;
                     procHalt <= 1'b1;
                     state    <= frqNew[`CCS_FRQ_PLL2] ? ST_STAB2 : ST_STAB1;
                  end else if (busHalt) begin
                     procHalt <= 1'b1;
                     state    <= ST_STAB1;
                  end else begin
                     busTarget <= bus_field(frqNew);
                  end
               end
            end
            ST_STAB2: begin
               if (overflow) begin
                  pll2On <= 1'b1;
                  state  <= ST_STAB1;
               end
            end
            ST_STAB1: begin
               if (overflow) begin
                  // resume: timer stops unless its run bit is set, since the sequence no longer runs it
                  procHalt  <= 1'b0;
                  busTarget <= bus_field(freq_ctrl);
                  state     <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stabilization timer
   ccs_stab_timer timer (
      .clock     (clock),
      .rst       (rst),
      .cntWrite  (cntWrite),
      .csrWrite  (csrWrite),
      .wrData    (hwdata[7:0]),
      .seqRun    (state != ST_RUN),
      .seqReload (state == ST_STAB2 && overflow),
      .count     (count),
      .ctrl      (ctrl),
      .overflow  (overflow)
   );

   ////////////////////////////////////////////////////////////////////
   // derived clocks on a shared base count
   always @(posedge clock) begin
      if (rst)
         base <= `CCS_BASE_ZERO;
      else if (base == `CCS_BASE_LAST)
         base <= `CCS_BASE_ZERO;
      else
         base <= base + 5'h01;
   end

   ccs_ratio_div cpuDiv (
      .clock     (clock),
      .rst       (rst),
      .base      (base),
      .target    (cpu_field(freq_ctrl)),
      .periph    (1'b0),
      .hold      (procHalt),
      .resetCode (cpu_field(FRQ_INIT)),
      .tick      (cpuT),
      .level     (),
      .current   ()
   );

   ccs_ratio_div busDiv (
      .clock     (clock),
      .rst       (rst),
      .base      (base),
      .target    (busTarget),
      .periph    (1'b0),
      .hold      (procHalt),
      .resetCode (bus_field(FRQ_INIT)),
      .tick      (busT),
      .level     (busLevel),
      .current   ()
   );

   ccs_ratio_div perDiv (
      .clock     (clock),
      .rst       (rst),
      .base      (base),
      .target    (per_field(freq_ctrl)),
      .periph    (1'b1),
      .hold      (procHalt),
      .resetCode (per_field(FRQ_INIT)),
      .tick      (perT),
      .level     (),
      .current   ()
   );

   ////////////////////////////////////////////////////////////////////
   // clock enables, stopped in the same cycle as the halt flag rises
   always @(posedge clock) begin
      if (rst) begin
         cpuTick    <= 1'b0;
         busTick    <= 1'b0;
         periphTick <= 1'b0;
      end else begin
         cpuTick    <= cpuT && !haltNow;
         busTick    <= busT && !haltNow;
         periphTick <= perT && !haltNow;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // external clock pin
   always @(posedge clock) begin
      if (rst) begin
         unstable    <= 1'b0;
         extClockOut <= 1'b0;
         extClockOe  <= 1'b1;
      end else begin
         unstable    <= !unstable;
         // while halted the pin toggles every source cycle
         extClockOut <= haltNow ? unstable : busLevel;
         extClockOe  <= freq_ctrl[`CCS_FRQ_OUT_EN];
      end
   end
endmodule // ccs_sequencer
`default_nettype wire

// ==== design/ccs_stab_timer.v ====
// stabilization timer: 8-bit up counter with prescaler and control/status byte
// assumes writes arrive already key-checked from the bus slave
`timescale 1ns/1ns
`default_nettype none
`include "ccs_regs.vh"
module ccs_stab_timer (
   input  wire       clock,     // source clock
   input  wire       rst,       // sync reset, active high
   input  wire       cntWrite,  // load counter
   input  wire       csrWrite,  // load control/status
   input  wire [7:0] wrData,    // write data
   input  wire       seqRun,    // sequencer counts stabilization
   input  wire       seqReload, // reload the initial value
   output reg  [7:0] count,     // stab_timer_count
   output reg  [7:0] ctrl,      // stab_timer_ctrl_status
   output reg        overflow   // one-cycle overflow pulse
);
   reg  [7:0]  initial_value;
   reg  [11:0] prescale;
   // select 0 steps every 32 cycles, each select step doubles the span
   wire [11:0] mask = `CCS_PRE_MAX_MASK >> (~ctrl[`CCS_CSR_SEL_HI:`CCS_CSR_SEL_LO]);
   wire        running = seqRun || ctrl[`CCS_CSR_RUN];
   wire        step = running && ((prescale & mask[11:0]) == mask[11:0]);

   always @(posedge clock) begin
      if (rst) begin
         count         <= `CCS_CNT_RESET;
         ctrl          <= `CCS_CSR_RESET;
         initial_value <= `CCS_CNT_RESET;
         prescale      <= `CCS_PRE_ZERO;
         overflow      <= 1'b0;
      end else begin
         overflow <= 1'b0;
         if (csrWrite)
            ctrl <= wrData;
         if (!running)
            prescale <= `CCS_PRE_ZERO;
         else
            prescale <= prescale + 12'h001;
         if (cntWrite) begin
            count         <= wrData;
            initial_value <= wrData;
         end else if (seqReload) begin
            count <= initial_value;
         end else if (step) begin
            count <= count + 8'h01;
            if (count == `CCS_CNT_MAX)
               overflow <= 1'b1;
         end
      end
   end
endmodule // ccs_stab_timer
`default_nettype wire

// ==== tb/ccs_sequencer_properties.sv ====
// checker for the clock ratio and pll sequencer: bus answers, halt and tick relations
// assumes it is bound to ccs_sequencer and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "ccs_regs.vh"
module ccs_sequencer_props (
   input wire logic        clock,       // source clock
   input wire logic        rst,         // sync reset
   input wire logic        hsel,        // slave select
   input wire logic [31:0] haddr,       // address
   input wire logic [1:0]  htrans,      // transfer type
   input wire logic        hwrite,      // write
   input wire logic        hready,      // bus ready in
   input wire logic [31:0] hrdata,      // read data
   input wire logic        hreadyout,   // slave ready
   input wire logic        hresp,       // response
   input wire logic        pll1On,      // first pll on
   input wire logic        procHalt,    // halted
   input wire logic        cpuTick,     // cpu enable
   input wire logic        busTick,     // bus enable
   input wire logic        periphTick,  // peripheral enable
   input wire logic        extClockOut  // pin value
);
   logic        rdPend;
   logic [31:0] rdAddr;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // read data phase tracking
   always @(posedge clock) begin
      if (rst) begin
         rdPend <= 1'b0;
         rdAddr <= 32'h0000_0000;
      end else begin
         rdPend <= hsel && hready && htrans[1] && !hwrite;
         rdAddr <= haddr;
      end
   end
   ////////////////////////////////////////////////////////////
   bus_okay_ready_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   halt_no_tick_a: assert property (procHalt |-> !cpuTick && !busTick && !periphTick)
      else $error("derived tick while halted");
   halt_pin_toggle_a: assert property (procHalt && $past(procHalt) |-> extClockOut != $past(extClockOut))
      else $error("pin clock frozen while halted");
   periph_tick_gap_a: assert property (periphTick |=> !periphTick)
      else $error("peripheral ticks back to back");
   halt_needs_pll_a: assert property ($rose(procHalt) |-> ##[0:2] pll1On)
      else $error("halt without first pll on");
   resume_ticks_a: assert property ($fell(procHalt) |-> ##[0:24] cpuTick)
      else $error("no cpu tick after resume");
   timer_read_byte_a: assert property (rdPend && (rdAddr == `CCS_ADDR_COUNT || rdAddr == `CCS_ADDR_CSR)
      |-> hrdata[31:8] == 24'h00_0000)
      else $error("timer read wider than a byte");
   freq_read_res_a: assert property (rdPend && rdAddr == `CCS_ADDR_FREQ |-> hrdata[31:12] == 20'h0_0000)
      else $error("reserved frequency bits not zero");
endmodule // ccs_sequencer_props
bind ccs_sequencer ccs_sequencer_props chk (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
   .hreadyout, .hresp, .pll1On, .procHalt, .cpuTick, .busTick, .periphTick, .extClockOut);
`default_nettype wire

// ==== tb/tb_clock_ratio_pll_sequencer.sv ====
// testbench of the clock ratio and pll sequencer: register bus tasks and sequences
// assumes the sequencer answers with zero wait states and the checker is bound
`timescale 1ns/1ns
`default_nettype none
`include "ccs_regs.vh"
`define CHECK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nMismatch++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_clock_ratio_pll_sequencer;
   logic        clock, rst, hsel, hwrite, hrespOut, hreadyOut;
   logic        pll1On, pll2On, procHalt, cpuTick, busTick, periphTick, extClockOut, extClockOe;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rdData;
   int          nMismatch, samplesChecked;
   int          cdiv[6] = '{1, 2, 3, 4, 6, 8};
   int          pdiv[5] = '{2, 3, 4, 6, 8};
   ccs_sequencer dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyOut), .hrdata(hrdata), .hreadyout(hreadyOut),
      .hresp(hrespOut), .pll1On(pll1On), .pll2On(pll2On), .procHalt(procHalt), .cpuTick(cpuTick),
      .busTick(busTick), .periphTick(periphTick), .extClockOut(extClockOut), .extClockOe(extClockOe));
   ////////////////////////////////////////////////////////////
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= sz;
      @(posedge clock);
      while (hreadyOut !== 1'b1) @(posedge clock);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clock);
      while (hreadyOut !== 1'b1) @(posedge clock);
      rdData = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] e);
      xfer(1'b0, a, sz, 32'h0000_0000);
      `CHECK($sformatf("read %h", a), e, rdData)
   endtask
   task automatic setf(input logic [15:0] v);
      xfer(1'b1, `CCS_ADDR_FREQ, `CCS_HSIZE_HALF, {16'h0000, v});
      rd(`CCS_ADDR_FREQ, `CCS_HSIZE_WORD, {16'h0000, v & `CCS_FRQ_WMASK});
   endtask
   // initial count 0xFC: four prescaled steps to overflow
   task automatic arm;
      xfer(1'b1, `CCS_ADDR_COUNT, `CCS_HSIZE_HALF, 32'h0000_5AFC);
   endtask
   task automatic ticks(input int sel, input int e);
      int n;
      n = 0;
      repeat (30) @(posedge clock);
      repeat (48) begin
         @(posedge clock);
         n += (sel == 0) ? (cpuTick === 1'b1) : (sel == 1) ? (busTick === 1'b1) : (periphTick === 1'b1);
      end
      `CHECK("tick count", e, n)
      `CHECK("procHalt", 1'b0, procHalt)
   endtask
   task automatic halt(input int lo, input int hi);
      int n;
      n = 0;
      while (procHalt !== 1'b1 && n < 8) begin
         @(posedge clock);
         n++;
      end
      n = 0;
      while (procHalt === 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      `CHECK("halt length in range", 1'b1, n >= lo && n <= hi)
   endtask
   task automatic wrap_up;
      if (nMismatch == 0 && samplesChecked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #80000;
      nMismatch++;
      wrap_up;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      `CHECK("extClockOe", 1'b1, extClockOe)
      rd(`CCS_ADDR_FREQ, `CCS_HSIZE_WORD, 32'h0000_0E13);
      rd(`CCS_ADDR_COUNT, `CCS_HSIZE_BYTE, 32'h0000_0000);
      rd(`CCS_ADDR_CSR, `CCS_HSIZE_BYTE, 32'h0000_0000);
      xfer(1'b1, `CCS_ADDR_COUNT, `CCS_HSIZE_HALF, 32'h0000_A533);
      xfer(1'b1, `CCS_ADDR_CSR, `CCS_HSIZE_HALF, 32'h0000_5A05);
      xfer(1'b1, `CCS_ADDR_COUNT, `CCS_HSIZE_BYTE, 32'h0000_5A33);
      rd(`CCS_ADDR_COUNT, `CCS_HSIZE_BYTE, 32'h0000_0000);
      rd(`CCS_ADDR_CSR, `CCS_HSIZE_BYTE, 32'h0000_0000);
      xfer(1'b1, `CCS_ADDR_CSR, `CCS_HSIZE_HALF, 32'h0000_A503);
      rd(`CCS_ADDR_CSR, `CCS_HSIZE_BYTE, 32'h0000_0003);
      xfer(1'b1, `CCS_ADDR_CSR, `CCS_HSIZE_HALF, 32'h0000_A500);
      arm;
      rd(`CCS_ADDR_COUNT, `CCS_HSIZE_BYTE, 32'h0000_00FC);
      setf(16'h0E0B);
      halt(90, 200);
      for (int c = 0; c < 6; c++) begin
         setf(16'h0E08 | (c << 6));
         ticks(0, 48 / cdiv[c]);
      end
      for (int p = 0; p < 5; p++) begin
         setf(16'h0E08 | p);
         ticks(2, 48 / pdiv[p]);
      end
      setf(16'h0C08);
      `CHECK("pll2On", 1'b0, pll2On)
      for (int b = 0; b < 6; b++) begin
         setf(16'h0C00 | (b << 3));
         ticks(1, 48 / cdiv[b]);
      end
      setf(16'h0800);
      `CHECK("pll1On", 1'b0, pll1On)
      arm;
      setf(16'h0C00);
      halt(90, 200);
      `CHECK("pll1On", 1'b1, pll1On)
      `CHECK("pll2On", 1'b0, pll2On)
      setf(16'h0A00);
      arm;
      setf(16'h0E00);
      halt(220, 360);
      `CHECK("pll2On", 1'b1, pll2On)
      repeat (64) @(posedge clock);
      rd(`CCS_ADDR_COUNT, `CCS_HSIZE_BYTE, 32'h0000_0000);
      setf(16'h0600);
      repeat (2) @(posedge clock);
      `CHECK("extClockOe", 1'b0, extClockOe)
      setf(16'h0E00);
      repeat (2) @(posedge clock);
      `CHECK("extClockOe", 1'b1, extClockOe)
      xfer(1'b1, 32'hFFC0_0004, `CCS_HSIZE_WORD, 32'h1234_5678);
      rd(32'hFFC0_0004, `CCS_HSIZE_WORD, 32'h0000_0000);
      wrap_up;
   end
endmodule // tb_clock_ratio_pll_sequencer
`default_nettype wire
